// ==== rtl/pifb_defs.vh ====
`ifndef PIFB_DEFS_VH
`define PIFB_DEFS_VH

// register byte addresses on the apb bus
`define PIFB_ADDR_FLAG_ONE 12'h000
`define PIFB_ADDR_FLAG_TWO 12'h004
`define PIFB_ADDR_IRQ_STATUS 12'h008
`define PIFB_ADDR_IRQ_MASK 12'h00C

// reset values
`define PIFB_RST_FLAG_ONE 8'h00
`define PIFB_RST_FLAG_TWO 8'h00
`define PIFB_RST_IRQ_STATUS 9'h000
`define PIFB_RST_IRQ_MASK 9'h000

// field positions in the first flag register
`define PIFB_BIT_PARALLEL 7
`define PIFB_BIT_CONVERTER 6
`define PIFB_BIT_RECEIVE 5
`define PIFB_BIT_TRANSMIT 4
`define PIFB_BIT_SYNC_SERIAL 3
`define PIFB_BIT_CAPCOMP 2
`define PIFB_BIT_TIMER_TWO 1
`define PIFB_BIT_TIMER_ONE 0

// field position in the second flag register
`define PIFB_BIT_COMPARATOR 6

// software-writable bits; receive and transmit flags are read-only
`define PIFB_ONE_WR_MASK 8'hCF
`define PIFB_TWO_WR_MASK 8'h40

// capture/compare unit operating modes
`define PIFB_CCP_OFF 2'h0
`define PIFB_CCP_CAPTURE 2'h1
`define PIFB_CCP_COMPARE 2'h2
`define PIFB_CCP_PWM 2'h3

// number of event sources feeding the interrupt status register
`define PIFB_NUM_EVENTS 9

`endif

// ==== rtl/pifb_peripheral_irq_flag_bank.v ====
`timescale 1ns/100ps
`include "pifb_defs.vh"

module pifb_peripheral_irq_flag_bank (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // device configuration levels
  input wire mcu_mode,
  input wire large_package,
  input wire [1:0] ccp_mode,
  // peripheral event pulses, same clock
  input wire psp_access_done,
  input wire adc_conversion_done,
  input wire serial_receive_load,
  input wire serial_receive_buffer_read,
  input wire serial_transmit_drain,
  input wire serial_transmit_buffer_write,
  input wire sync_serial_done,
  input wire ccp_capture,
  input wire ccp_compare_match,
  input wire timer_two_period_match,
  input wire timer_one_overflow,
  input wire comparator_change,
  // flag register contents and interrupt
  output reg [7:0] peripheral_flag_reg_one,
  output reg [7:0] peripheral_flag_reg_two,
  output reg irq
);

  // register map, one aligned 32-bit word each, upper bits read zero:
  //   flag one    7 parallel, 6 converter, 5 receive (ro), 4 transmit (ro),
  //               3 sync serial, 2 capture/compare, 1 timer two, 0 timer one
  //   flag two    6 comparator; every other position reads zero here
  //   irq status  7:0 follow flag one, 8 the comparator; a read clears it
  //   irq mask    same layout as status; irq high while status & mask set
  //
  // flags and status: two views of one event.
  // a flag is what software polls and, save receive and transmit, clears by writing;
  // a status bit is what raises irq and is cleared by reading.
  // kept apart so a polling loop and an interrupt handler
  // can share one source without racing over one bit.
  //
  // event inputs: one-cycle pulses from logic on pclk,
  // so none of them passes a synchroniser;
  // a source on another clock must be moved onto pclk first.
  //
  // clk_en low freezes every flop, the bus answer included:
  // a transfer simply waits, but an event pulse
  // that arrives while frozen is not seen at all.
  //
  // software is expected to clear a flag before it unmasks
  // the matching status bit, and again after servicing;
  // nothing here enforces that order.
  //
  // flag writes take lane 0 only; the mask takes lanes 0 and 1;
  // writes to status are answered and ignored.

  reg [8:0] irq_status;
  reg [8:0] irq_mask;
  reg [7:0] next_flag_one;
  reg [7:0] next_flag_two;
  localparam APB_IDLE = 1'b0;
  localparam APB_ANSWER = 1'b1;
  reg [7:0] set_one;
  reg [7:0] base_one;
  reg [7:0] clr_one;
  reg [31:0] next_prdata;
  reg [8:0] next_irq_mask;
  reg apb_state;
  reg next_apb_state;
  wire [8:0] next_irq_status;
  wire [7:0] keep_one;
  wire [7:0] wr_bit_one;
  wire [7:0] wr_mask_one;
  wire ccp_is_capture;
  wire ccp_is_compare;
  wire ccp_is_pwm;
  wire set_parallel;
  wire set_converter;
  wire set_receive;
  wire set_transmit;
  wire set_sync_serial;
  wire set_capture;
  wire set_compare;
  wire set_capcomp;
  wire set_timer_two;
  wire set_timer_one;
  wire set_comparator;
  wire sel_flag_one;
  wire sel_flag_two;
  wire sel_irq_status;
  wire sel_irq_mask;
  wire answer_now;
  wire [8:0] events;
  wire psp_enable;
  wire apb_done;
  wire wr_lane0;
  wire wr_flag_one;
  wire wr_flag_two;
  wire wr_irq_mask;
  wire rd_irq_status;
  wire addr_hit;

  // one-hot register select, shared by write strobes, read-clear and error; the read mux decodes paddr itself
  assign sel_flag_one = (paddr == `PIFB_ADDR_FLAG_ONE);
  assign sel_flag_two = (paddr == `PIFB_ADDR_FLAG_TWO);
  assign sel_irq_status = (paddr == `PIFB_ADDR_IRQ_STATUS);
  assign sel_irq_mask = (paddr == `PIFB_ADDR_IRQ_MASK);
  // anything else is answered with pslverr and has no effect
  assign addr_hit = sel_flag_one | sel_flag_two | sel_irq_status | sel_irq_mask;

  // access completes at the edge where pready is seen high;
  // writes and the read-clear act there and nowhere else,
  // so a stalled transfer leaves every register untouched
  assign apb_done = psel & penable & pready;
  // flag registers are one byte wide, only lane 0 matters to them
  assign wr_lane0 = apb_done & pwrite & pstrb[0];
  assign wr_flag_one = wr_lane0 & sel_flag_one;
  assign wr_flag_two = wr_lane0 & sel_flag_two;
  // mask spans nine bits, lanes are picked in the mask logic
  assign wr_irq_mask = apb_done & pwrite & sel_irq_mask;
  // status is read-only; a write to it is accepted and ignored
  assign rd_irq_status = apb_done & ~pwrite & sel_irq_status;

  // parallel port flag is dead outside microcontroller mode or on small parts
  assign psp_enable = mcu_mode & large_package;

  // capture/compare mode decode; the off mode decodes to none of these
  assign ccp_is_capture = (ccp_mode == `PIFB_CCP_CAPTURE);
  assign ccp_is_compare = (ccp_mode == `PIFB_CCP_COMPARE);
  assign ccp_is_pwm = (ccp_mode == `PIFB_CCP_PWM);

  // per-source set terms, never gated by the mask; only the parallel term takes its port enable
  // polling relies on this: a masked source still leaves its flag
  assign set_parallel = psp_access_done & psp_enable;
  assign set_converter = adc_conversion_done;
  assign set_receive = serial_receive_load;
  assign set_transmit = serial_transmit_drain;
  assign set_sync_serial = sync_serial_done;
  assign set_timer_two = timer_two_period_match;
  assign set_timer_one = timer_one_overflow;
  assign set_comparator = comparator_change;

  // a capture counts only in capture mode, a match only in compare mode
  assign set_capture = ccp_is_capture & ccp_capture;
  assign set_compare = ccp_is_compare & ccp_compare_match;
  // pwm may pulse both strobes; neither may reach the flag there
  assign set_capcomp = (set_capture | set_compare) & ~ccp_is_pwm;

  // set terms gathered in register bit order
  always @* begin
    set_one = 8'h00;
    set_one[`PIFB_BIT_PARALLEL] = set_parallel;
    set_one[`PIFB_BIT_CONVERTER] = set_converter;
    set_one[`PIFB_BIT_RECEIVE] = set_receive;
    set_one[`PIFB_BIT_TRANSMIT] = set_transmit;
    set_one[`PIFB_BIT_SYNC_SERIAL] = set_sync_serial;
    set_one[`PIFB_BIT_CAPCOMP] = set_capcomp;
    set_one[`PIFB_BIT_TIMER_TWO] = set_timer_two;
    set_one[`PIFB_BIT_TIMER_ONE] = set_timer_one;
  end

  // hardware clear terms; only the buffer pair clears itself
  // the other six flags wait for software, however long that takes, save parallel, which drops while its port is disabled
  always @* begin
    clr_one = 8'h00;
    clr_one[`PIFB_BIT_RECEIVE] = serial_receive_buffer_read;
    clr_one[`PIFB_BIT_TRANSMIT] = serial_transmit_buffer_write;
  end

  // bits a software write may touch; receive and transmit are read-only
  assign wr_mask_one = `PIFB_ONE_WR_MASK;

  // per bit: a write loads the bit, else a hardware clear drops it, else it holds
  genvar fi;
  generate
    for (fi = 0; fi < 8; fi = fi + 1) begin : g_flag_one
      assign wr_bit_one[fi] = wr_flag_one & wr_mask_one[fi];
      assign keep_one[fi] = wr_bit_one[fi] ? pwdata[fi] : (peripheral_flag_reg_one[fi] & ~clr_one[fi]);
    end
  endgenerate

  // first flag register: sets or-ed last, an event in a clear cycle is not lost
  always @* begin
    base_one = keep_one;
    next_flag_one = base_one | set_one;
    // the parallel flag cannot hold a one while its port is disabled
    next_flag_one[`PIFB_BIT_PARALLEL] = next_flag_one[`PIFB_BIT_PARALLEL] & psp_enable;
  end

  // second flag register: only the comparator bit is held here
  // unused positions are masked on every path, writes cannot reach them
  always @* begin
    next_flag_two = peripheral_flag_reg_two & `PIFB_TWO_WR_MASK;
    if (wr_flag_two) begin
      next_flag_two = pwdata[7:0] & `PIFB_TWO_WR_MASK;
    end
    next_flag_two[`PIFB_BIT_COMPARATOR] = next_flag_two[`PIFB_BIT_COMPARATOR] | set_comparator;
  end

  // event vector for the interrupt status, first register bits then comparator
  assign events = {comparator_change, set_one};

  // sticky status per event, read clears, set beats clear
  // status follows event pulses, not flag levels, so clearing
  // a flag by software leaves a pending interrupt in place
  genvar gi;
  generate
    for (gi = 0; gi < `PIFB_NUM_EVENTS; gi = gi + 1) begin : g_status
      assign next_irq_status[gi] = events[gi] | (irq_status[gi] & ~rd_irq_status);
    end
  endgenerate

  // mask write with byte lanes honoured: lane 0 bits 7:0, lane 1 bit 8
  always @* begin
    next_irq_mask = irq_mask;
    if (wr_irq_mask & pstrb[0]) begin
      next_irq_mask[7:0] = pwdata[7:0];
    end
    if (wr_irq_mask & pstrb[1]) begin
      next_irq_mask[8] = pwdata[8];
    end
  end

  // flag and interrupt state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_flag_reg_one <= `PIFB_RST_FLAG_ONE;
      peripheral_flag_reg_two <= `PIFB_RST_FLAG_TWO;
      irq_status <= `PIFB_RST_IRQ_STATUS;
      irq_mask <= `PIFB_RST_IRQ_MASK;
      irq <= 1'b0;
    end else if (clk_en) begin
      peripheral_flag_reg_one <= next_flag_one;
      peripheral_flag_reg_two <= next_flag_two;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      // computed from next values so irq tracks status with no lag
      // costs a longer path into this flop, saves a cycle of latency
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

  // apb answer: one wait state; the state only marks the answer cycle,
  // so back-to-back transfers need no idle cycle between them
  always @* begin
    next_apb_state = apb_state;
    case (apb_state)
      APB_IDLE: begin
        // first access cycle seen: answer on the next one
        if (psel & penable) begin
          next_apb_state = APB_ANSWER;
        end
      end
      APB_ANSWER: begin
        // answer lasts one cycle, a new setup may follow at once
        next_apb_state = APB_IDLE;
      end
      default: begin
        next_apb_state = APB_IDLE;
      end
    endcase
  end

  // the access cycle that launches the answer
  assign answer_now = (apb_state == APB_IDLE) & psel & penable;

  // read data chosen a cycle ahead so prdata comes straight from a flop
  always @* begin
    next_prdata = 32'h00000000;
    if (answer_now & ~pwrite) begin
      case (paddr)
        `PIFB_ADDR_FLAG_ONE: begin
          next_prdata = {24'h000000, peripheral_flag_reg_one};
        end
        `PIFB_ADDR_FLAG_TWO: begin
          // unused positions are already zero in the register
          next_prdata = {24'h000000, peripheral_flag_reg_two};
        end
        `PIFB_ADDR_IRQ_STATUS: begin
          // sample taken one cycle before the clearing edge; a set in that gap survives
          next_prdata = {23'h0, irq_status};
        end
        `PIFB_ADDR_IRQ_MASK: begin
          next_prdata = {23'h0, irq_mask};
        end
        default: begin
          // unmapped reads return zero alongside the error
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  // answer flops; clk_en low stalls the answer with everything else
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      apb_state <= next_apb_state;
      pready <= answer_now;
      pslverr <= answer_now & ~addr_hit;
      prdata <= next_prdata;
    end
  end

endmodule

// ==== tb/pifb_events.sv ====
`timescale 1ns/100ps
// peripheral side: every event is a one-cycle pulse on the bus clock
module pifb_events (
  input wire pclk,
  output logic [11:0] ev
);
  initial ev = 12'h000;
  // launched after an edge so the block sees it at exactly one edge
  task fire(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask
endmodule

// ==== tb/pifb_monitor.sv ====
`timescale 1ns/100ps
module pifb_monitor (
  input wire pclk, presetn, clk_en, psel, mcu_mode, large_package,
  input wire [1:0] ccp_mode,
  input wire adc_conversion_done, serial_receive_load, serial_receive_buffer_read, serial_transmit_drain,
  input wire serial_transmit_buffer_write, sync_serial_done, timer_two_period_match, timer_one_overflow,
  input wire comparator_change,
  input wire [7:0] peripheral_flag_reg_one, peripheral_flag_reg_two
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // set beats clear, so a lone pulse decides the bit
  wire [7:0] f1 = peripheral_flag_reg_one;
  a_conv_set: assert property (clk_en && adc_conversion_done |=> f1[6])
    else $error("converter flag missed");
  a_sync_set: assert property (clk_en && sync_serial_done |=> f1[3])
    else $error("sync serial flag missed");
  a_timer_two_count_set: assert property (clk_en && timer_two_period_match |=> f1[1])
    else $error("timer two flag missed");
  a_timer_one_count_set: assert property (clk_en && timer_one_overflow |=> f1[0])
    else $error("timer one flag missed");
  a_cmp_set: assert property (clk_en && comparator_change |=> peripheral_flag_reg_two[6])
    else $error("comparator flag missed");
  a_rx_clear: assert property (clk_en && serial_receive_buffer_read && !serial_receive_load |=> !f1[5])
    else $error("receive flag not cleared");
  a_tx_clear: assert property (clk_en && serial_transmit_buffer_write && !serial_transmit_drain |=> !f1[4])
    else $error("transmit flag not cleared");
  a_par_off: assert property (clk_en && !(mcu_mode && large_package) |=> !f1[7])
    else $error("parallel flag set while disabled");
  a_pwm_quiet: assert property (clk_en && ccp_mode == 2'h3 && !f1[2] && !psel |=> !f1[2])
    else $error("capcomp flag set in pwm mode");
  a_two_unused: assert property ((peripheral_flag_reg_two & 8'hBF) == 8'h00)
    else $error("unused flag bits not zero");
endmodule

// ==== tb/peripheral_irq_flag_bank_tb.sv ====
`timescale 1ns/100ps
`define CK(n, e, a) begin n_compared++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module peripheral_irq_flag_bank_tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, mcu_mode, large_package;
  logic pready, pslverr, irq, err;
  logic [11:0] paddr, ev;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] ccp_mode;
  logic [7:0] peripheral_flag_reg_one, peripheral_flag_reg_two;
  int n_errors = 0, n_compared = 0;
  wire psp_access_done = ev[11], adc_conversion_done = ev[10], serial_receive_load = ev[9];
  wire serial_receive_buffer_read = ev[8], serial_transmit_drain = ev[7], serial_transmit_buffer_write = ev[6];
  wire sync_serial_done = ev[5], ccp_capture = ev[4], ccp_compare_match = ev[3];
  wire timer_two_period_match = ev[2], timer_one_overflow = ev[1], comparator_change = ev[0];
  pifb_peripheral_irq_flag_bank uut (.*);
  pifb_events per (.pclk(pclk), .ev(ev));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rdk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CK(n, e, rd)
  endtask
  task t_reset;
    for (int a = 0; a < 16; a += 4) rdk("reset", a[11:0], 0);
  endtask
  task t_flags;
    int e[6] = '{11, 10, 5, 4, 2, 1};
    int b[6] = '{7, 6, 3, 2, 1, 0};
    for (int k = 0; k < 6; k++) begin
      per.fire(e[k]);
      rdk("set", 0, 32'h1 << b[k]);
      apb(1, 0, 0);
      rdk("clear", 0, 0);
    end
    mcu_mode <= 0;
    per.fire(11);
    rdk("parallel off", 0, 0);
  endtask
  task t_ccp;
    {mcu_mode, ccp_mode} <= 3'b110;
    per.fire(4);
    rdk("cap in cmp", 0, 0);
    per.fire(3);
    rdk("match", 0, 4);
    apb(1, 0, 0);
    ccp_mode <= 3;
    per.fire(3);
    per.fire(4);
    rdk("pwm", 0, 0);
  endtask
  task t_auto;
    per.fire(9);
    per.fire(7);
    rdk("rx tx", 0, 32'h30);
    apb(1, 0, 32'hFF);
    rdk("read only", 0, 32'hFF);
    per.fire(8);
    per.fire(6);
    apb(1, 0, 0);
    rdk("self clear", 0, 0);
    per.fire(0);
    rdk("cmp", 4, 32'h40);
    apb(1, 4, 32'hFF);
    rdk("unused", 4, 32'h40);
    apb(1, 4, 0);
  endtask
  // unmasked event raises irq, status read drops it, mask blocks it
  task t_irq;
    rdk("status acc", 8, 32'h1FF);
    apb(1, 12'h00C, 1);
    per.fire(1);
    @(negedge pclk);
    `CK("irq", 1'b1, irq)
    rdk("status", 8, 1);
    @(negedge pclk);
    `CK("irq clr", 1'b0, irq)
    apb(1, 12'h00C, 0);
    per.fire(1);
    @(negedge pclk);
    `CK("irq masked", 1'b0, irq)
    rdk("status masked", 8, 1);
    apb(0, 12'h010, 0);
    `CK("slverr", 1'b1, err)
  endtask
  // byte lanes, a frozen clock enable and the small package
  task t_misc;
    apb(1, 0, 0);
    pstrb <= 4'hE;
    apb(1, 0, 32'hFF);
    pstrb <= 4'h2;
    apb(1, 12'h00C, 32'h1FF);
    pstrb <= 4'hF;
    rdk("lane0 off", 0, 0);
    rdk("lane1 only", 12'h00C, 32'h100);
    clk_en <= 0;
    per.fire(1);
    clk_en <= 1;
    rdk("frozen", 0, 0);
    large_package <= 0;
    per.fire(11);
    rdk("small part", 0, 0);
    large_package <= 1;
  endtask
  task give_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {presetn, clk_en, psel, penable, pwrite, mcu_mode, large_package} <= 7'b0100011;
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
    pstrb <= 4'hF;
    ccp_mode <= 2'h1;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_flags;
    t_ccp;
    t_auto;
    t_irq;
    t_misc;
    give_verdict;
  end
  // cuts a hang well past the expected few hundred cycles
  initial begin
    #100us;
    n_errors++;
    give_verdict;
  end
endmodule
bind pifb_peripheral_irq_flag_bank pifb_monitor mon (.*);
